// [inc/t2rc_defines.svh]
// register indices, field positions, reset values of the second timer
// assumes a 32-bit apb with byte address equal to four times the index
`ifndef T2RC_DEFINES_SVH
`define T2RC_DEFINES_SVH

`define T2RC_IDX_CTRL     14'h0418
`define T2RC_IDX_MODE     14'h0419
`define T2RC_IDX_CNT_LO   14'h041a
`define T2RC_IDX_CNT_HI   14'h041b
`define T2RC_IDX_RLD_LO   14'h041c
`define T2RC_IDX_RLD_HI   14'h041d
`define T2RC_IDX_CAP_LO   14'h041e
`define T2RC_IDX_CAP_HI   14'h041f
`define T2RC_IDX_IST      14'h0420
`define T2RC_IDX_IMASK    14'h0421

`define T2RC_CTL_WRAP     7
`define T2RC_CTL_EXT      6
`define T2RC_CTL_A_RX     5
`define T2RC_CTL_A_TX     4
`define T2RC_CTL_EXT_EN   3
`define T2RC_CTL_RUN      2
`define T2RC_CTL_SRC      1
`define T2RC_CTL_CRSEL    0
`define T2RC_MODE_B_RX    5
`define T2RC_MODE_B_TX    4
`define T2RC_MODE_DOWN_COUNT_ENABLE    0
`define T2RC_MODE_WMASK   8'h31

`define T2RC_IST_WRAP     0
`define T2RC_IST_EXT      1

`define T2RC_CTL_RST      8'h00
`define T2RC_MODE_RST     8'h00
`define T2RC_CNT_RST      16'h0000
`define T2RC_CNT_TOP      16'hffff

`endif

// [inc/t2rc_edge_if.sv]
// edge events passed from the pin detector to the timer core
// assumes both ends run on the one timer clock
`timescale 1ns/100ps
`default_nettype none
interface t2rc_edge_if;
  logic trig_fall;
  logic count_fall;
  modport src (output trig_fall, output count_fall);
  modport snk (input trig_fall, input count_fall);
endinterface
`default_nettype wire

// [inc/t2rc_pkg.sv]
// types shared by the second timer modules
// assumes t2rc_defines.svh for all numbers
package t2rc_pkg;
  typedef enum logic [1:0] {
    T2RC_RELOAD,
    T2RC_UPDOWN,
    T2RC_CAPTURE,
    T2RC_BAUD
  } t2rc_mode_t;
endpackage

// [rtl/t2rc_edge_detect.sv]
// falling-edge detector for the trigger and count pins
// assumes pins already synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module t2rc_edge_detect (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic trig_pin,
  input  wire logic count_pin,
  t2rc_edge_if.src  edges
);
  logic trig_prev_q;
  logic count_prev_q;

  // previous level resets low so a pin held low is no edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_prev_q  <= 1'b0;
      count_prev_q <= 1'b0;
    end else begin
      trig_prev_q  <= trig_pin;
      count_prev_q <= count_pin;
    end
  end

  assign edges.trig_fall  = trig_prev_q & ~trig_pin;
  assign edges.count_fall = count_prev_q & ~count_pin;
endmodule
`default_nettype wire

// [rtl/t2rc_timer.sv]
// second timer: 16-bit reload, capture and baud timer behind apb
// assumes synchronous pins and a one-cycle prescaled tick from outside
//
// The implementer's own choice: the APB register port.
`include "t2rc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - outside baud mode, source select 0 counts prescaled ticks, 1 counts count pin falling edges.
// - counter counts only while run bit is set; a reload-mode trigger edge reloads it even when stopped.
// - overflow or underflow sets the wrap flag outside baud mode.
// - capture mode without trigger enable is a plain 16-bit counter.
// - capture mode trigger falling edge copies count into capture registers.
// - capturing edge sets external event flag, which may interrupt.
// - reload mode overflow loads counter from reload registers.
// - reload mode trigger falling edge reloads counter and sets event flag.
// - without down enable, count up only, overflowing after ffff.
// - with down enable outside capture and baud mode, trigger pin high counts up, low counts down.
// - up/down overflow past ffff reloads and sets wrap flag.
// - counting down, equality with reload loads ffff and sets wrap flag.
// - up/down mode toggles event flag on wrap, no interrupt from it.
// - wrap or event flag raises interrupt when enabled; software clears them.
// - each uart select routes overflow rate to that uart direction.
// - baud mode counts prescaled ticks.
// - baud mode roll-overs never request the interrupt.
module t2rc_timer
  import t2rc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        prescaled_timer_clock,
  input  wire logic        ext_trigger_pin,
  input  wire logic        count_pin,
  output var  logic        uart_a_tx_baud,
  output var  logic        uart_a_rx_baud,
  output var  logic        uart_b_tx_baud,
  output var  logic        uart_b_rx_baud,
  output var  logic        irq
);

  function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
    return a[15:2] == idx;
  endfunction

  function automatic t2rc_mode_t decode_mode(input logic [7:0] c, input logic [7:0] m);
    if (c[`T2RC_CTL_A_RX] | c[`T2RC_CTL_A_TX] | m[`T2RC_MODE_B_RX] | m[`T2RC_MODE_B_TX])
      return T2RC_BAUD;
    else if (c[`T2RC_CTL_CRSEL])
      return T2RC_CAPTURE;
    else if (m[`T2RC_MODE_DOWN_COUNT_ENABLE])
      return T2RC_UPDOWN;
    else
      return T2RC_RELOAD;
  endfunction

  t2rc_edge_if edges ();

  t2rc_edge_detect u_edge (
    .clk       (clk),
    .reset     (reset),
    .trig_pin  (ext_trigger_pin),
    .count_pin (count_pin),
    .edges     (edges.src)
  );

  logic [7:0]  ctl_q;
  logic [7:0]  mode_q;
  logic [15:0] cnt_q;
  logic [15:0] rld_q;
  logic [15:0] cap_q;
  logic [1:0]  ist_q;
  logic [1:0]  imask_q;
  logic        wr_acc;
  logic        setup;
  logic        wr_ctl;
  logic        wr_mode;
  logic        wr_cnt_lo;
  logic        wr_cnt_hi;
  logic        wr_ist;
  t2rc_mode_t  mode;
  logic        tick;
  logic        count_up;
  logic        ovf;
  logic        unf;
  logic        wrap_evt;
  logic        trig_evt;
  logic        wrap_irq;
  logic [31:0] rd_mux;
  logic        mapped;

  assign wr_acc    = psel & penable & pready & pwrite;
  assign setup     = psel & ~penable;
  assign wr_ctl    = wr_acc & hit(paddr, `T2RC_IDX_CTRL);
  assign wr_mode   = wr_acc & hit(paddr, `T2RC_IDX_MODE);
  assign wr_cnt_lo = wr_acc & hit(paddr, `T2RC_IDX_CNT_LO);
  assign wr_cnt_hi = wr_acc & hit(paddr, `T2RC_IDX_CNT_HI);
  assign wr_ist    = wr_acc & hit(paddr, `T2RC_IDX_IST);

  assign mode = decode_mode(ctl_q, mode_q);

  // baud mode ignores the source bit and always takes the prescaled tick
  assign tick = ctl_q[`T2RC_CTL_RUN] &
                ((mode == T2RC_BAUD || !ctl_q[`T2RC_CTL_SRC]) ? prescaled_timer_clock
                                                              : edges.count_fall);
  assign count_up = (mode != T2RC_UPDOWN) | ext_trigger_pin;
  assign ovf      = tick & count_up & (cnt_q == `T2RC_CNT_TOP);
  assign unf      = tick & ~count_up & (cnt_q == rld_q);
  assign wrap_evt = ovf | unf;
  assign wrap_irq = wrap_evt & (mode != T2RC_BAUD);
  // the trigger pin only steers direction in up/down mode
  assign trig_evt = edges.trig_fall & ctl_q[`T2RC_CTL_EXT_EN] &
                    (mode == T2RC_CAPTURE || mode == T2RC_RELOAD);

  // software write to the count wins over any hardware load that cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= `T2RC_CNT_RST;
    end else if (wr_cnt_lo | wr_cnt_hi) begin
      if (wr_cnt_lo) cnt_q[7:0] <= pwdata[7:0];
      if (wr_cnt_hi) cnt_q[15:8] <= pwdata[7:0];
    end else if (unf) begin
      cnt_q <= `T2RC_CNT_TOP;
    end else if (ovf) begin
      cnt_q <= (mode == T2RC_CAPTURE) ? `T2RC_CNT_RST : rld_q;
    end else if (trig_evt && mode == T2RC_RELOAD) begin
      cnt_q <= rld_q;
    end else if (tick) begin
      cnt_q <= count_up ? 16'(cnt_q + 16'h0001) : 16'(cnt_q - 16'h0001);
    end
  end

  // control: hardware set of a flag beats a same-cycle software clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_q <= `T2RC_CTL_RST;
    end else begin
      if (wr_ctl) ctl_q <= pwdata[7:0];
      if (wrap_irq) ctl_q[`T2RC_CTL_WRAP] <= 1'b1;
      if (trig_evt) ctl_q[`T2RC_CTL_EXT] <= 1'b1;
      else if (wrap_evt && mode == T2RC_UPDOWN)
        ctl_q[`T2RC_CTL_EXT] <= ~ctl_q[`T2RC_CTL_EXT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) mode_q <= `T2RC_MODE_RST;
    else if (wr_mode) mode_q <= pwdata[7:0] & `T2RC_MODE_WMASK;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rld_q <= `T2RC_CNT_RST;
    end else if (wr_acc) begin
      if (hit(paddr, `T2RC_IDX_RLD_LO)) rld_q[7:0] <= pwdata[7:0];
      if (hit(paddr, `T2RC_IDX_RLD_HI)) rld_q[15:8] <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cap_q <= `T2RC_CNT_RST;
    end else if (trig_evt && mode == T2RC_CAPTURE) begin
      cap_q <= cnt_q;
    end else if (wr_acc) begin
      if (hit(paddr, `T2RC_IDX_CAP_LO)) cap_q[7:0] <= pwdata[7:0];
      if (hit(paddr, `T2RC_IDX_CAP_HI)) cap_q[15:8] <= pwdata[7:0];
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ist_q <= 2'b00;
    end else begin
      ist_q <= (ist_q & ~(wr_ist ? pwdata[1:0] : 2'b00)) | {trig_evt, wrap_irq};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) imask_q <= 2'b00;
    else if (wr_acc && hit(paddr, `T2RC_IDX_IMASK)) imask_q <= pwdata[1:0];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) irq <= 1'b0;
    else irq <= |(ist_q & imask_q);
  end

  // baud outputs pulse once per overflow, one cycle late
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      uart_a_tx_baud <= 1'b0;
      uart_a_rx_baud <= 1'b0;
      uart_b_tx_baud <= 1'b0;
      uart_b_rx_baud <= 1'b0;
    end else begin
      uart_a_tx_baud <= ovf & ctl_q[`T2RC_CTL_A_TX];
      uart_a_rx_baud <= ovf & ctl_q[`T2RC_CTL_A_RX];
      uart_b_tx_baud <= ovf & mode_q[`T2RC_MODE_B_TX];
      uart_b_rx_baud <= ovf & mode_q[`T2RC_MODE_B_RX];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr[15:2])
      `T2RC_IDX_CTRL:   rd_mux[7:0] = ctl_q;
      `T2RC_IDX_MODE:   rd_mux[7:0] = mode_q;
      `T2RC_IDX_CNT_LO: rd_mux[7:0] = cnt_q[7:0];
      `T2RC_IDX_CNT_HI: rd_mux[7:0] = cnt_q[15:8];
      `T2RC_IDX_RLD_LO: rd_mux[7:0] = rld_q[7:0];
      `T2RC_IDX_RLD_HI: rd_mux[7:0] = rld_q[15:8];
      `T2RC_IDX_CAP_LO: rd_mux[7:0] = cap_q[7:0];
      `T2RC_IDX_CAP_HI: rd_mux[7:0] = cap_q[15:8];
      `T2RC_IDX_IST:    rd_mux[1:0] = ist_q;
      `T2RC_IDX_IMASK:  rd_mux[1:0] = imask_q;
      default:          mapped = 1'b0;
    endcase
  end

  // one wait-free access: data is sampled in setup, so a count read
  // shows the value one cycle before the access edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_up_wrap;
    ovf && !wr_cnt_lo && !wr_cnt_hi;
  endsequence

  sequence s_down_hit;
    unf && !wr_cnt_lo && !wr_cnt_hi;
  endsequence

  property p_hold_stopped;
    !ctl_q[`T2RC_CTL_RUN] && !wr_cnt_lo && !wr_cnt_hi && !trig_evt |=> $stable(cnt_q);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("counter moved while stopped");

  property p_ext_source;
    ctl_q[`T2RC_CTL_RUN] && ctl_q[`T2RC_CTL_SRC] && mode != T2RC_BAUD && !edges.count_fall
      && !wr_cnt_lo && !wr_cnt_hi && !trig_evt |=> $stable(cnt_q);
  endproperty
  a_ext_source: assert property (p_ext_source) else $error("counted without a count pin edge");

  property p_reload_wrap;
    s_up_wrap ##0 (mode == T2RC_RELOAD || mode == T2RC_UPDOWN) && !wr_ctl
      |=> cnt_q == $past(rld_q) && ctl_q[`T2RC_CTL_WRAP];
  endproperty
  a_reload_wrap: assert property (p_reload_wrap) else $error("overflow did not reload");

  property p_down_wrap;
    s_down_hit ##0 !wr_ctl |=> cnt_q == `T2RC_CNT_TOP && ctl_q[`T2RC_CTL_WRAP];
  endproperty
  a_down_wrap: assert property (p_down_wrap) else $error("down match did not load top");

  property p_up_step;
    tick && mode == T2RC_UPDOWN && ext_trigger_pin && cnt_q != `T2RC_CNT_TOP
      && !wr_cnt_lo && !wr_cnt_hi |=> cnt_q == 16'($past(cnt_q) + 16'h0001);
  endproperty
  a_up_step: assert property (p_up_step) else $error("up count step wrong");

  property p_capture;
    trig_evt && mode == T2RC_CAPTURE && !wr_ctl
      |=> cap_q == $past(cnt_q) && ctl_q[`T2RC_CTL_EXT] && ist_q[`T2RC_IST_EXT]
      ##1 irq || !$past(imask_q[`T2RC_IST_EXT]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture edge lost");

  property p_toggle17;
    wrap_evt && mode == T2RC_UPDOWN && !wr_ctl && !wr_ist && !ist_q[`T2RC_IST_EXT]
      |=> ctl_q[`T2RC_CTL_EXT] != $past(ctl_q[`T2RC_CTL_EXT]) && !ist_q[`T2RC_IST_EXT];
  endproperty
  a_toggle17: assert property (p_toggle17) else $error("event bit did not toggle");

  property p_baud_quiet;
    ovf && mode == T2RC_BAUD && !ist_q[`T2RC_IST_WRAP] && !wr_ctl && !ctl_q[`T2RC_CTL_WRAP]
      |=> !ist_q[`T2RC_IST_WRAP] && !ctl_q[`T2RC_CTL_WRAP];
  endproperty
  a_baud_quiet: assert property (p_baud_quiet) else $error("baud roll-over flagged");

  property p_baud_route;
    ovf && ctl_q[`T2RC_CTL_A_TX]
      |=> uart_a_tx_baud ##1 uart_a_tx_baud == $past(ovf && ctl_q[`T2RC_CTL_A_TX]);
  endproperty
  a_baud_route: assert property (p_baud_route) else $error("uart a tx baud pulse wrong");

  property p_irq;
    (ist_q & imask_q) != 2'b00 |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_irq_low;
    (ist_q & imask_q) == 2'b00 |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt with no unmasked status");

  property p_wrap_sets;
    wrap_evt && mode != T2RC_BAUD && !wr_ctl |=> ctl_q[`T2RC_CTL_WRAP] && ist_q[`T2RC_IST_WRAP];
  endproperty
  a_wrap_sets: assert property (p_wrap_sets) else $error("wrap did not set the flags");

  property p_capture_wrap;
    s_up_wrap ##0 mode == T2RC_CAPTURE |=> cnt_q == `T2RC_CNT_RST;
  endproperty
  a_capture_wrap: assert property (p_capture_wrap) else $error("capture overflow did not wrap to zero");

  property p_trig_reload;
    trig_evt && mode == T2RC_RELOAD && !ovf && !wr_cnt_lo && !wr_cnt_hi && !wr_ctl
      |=> cnt_q == $past(rld_q) && ctl_q[`T2RC_CTL_EXT];
  endproperty
  a_trig_reload: assert property (p_trig_reload) else $error("trigger edge did not reload");

  property p_down_step;
    tick && mode == T2RC_UPDOWN && !ext_trigger_pin && cnt_q != rld_q
      && !wr_cnt_lo && !wr_cnt_hi |=> cnt_q == 16'($past(cnt_q) - 16'h0001);
  endproperty
  a_down_step: assert property (p_down_step) else $error("down count step wrong");

  // count pin edges must not move a baud counter
  property p_baud_source;
    mode == T2RC_BAUD && ctl_q[`T2RC_CTL_RUN] && !prescaled_timer_clock
      && !wr_cnt_lo && !wr_cnt_hi |=> $stable(cnt_q);
  endproperty
  a_baud_source: assert property (p_baud_source) else $error("baud counter moved without a tick");

endmodule
`default_nettype wire

// [test/t2rc_pins.sv]
// pin-side model: tick source, trigger and count pins, baud pulse counters
// assumes tb_top calls its tasks; pins change only after a rising edge
`timescale 1ns/100ps
`default_nettype none
module t2rc_pins (
  input  wire logic       clk,
  input  wire logic [3:0] baud,
  output var  logic       tick,
  output var  logic       trig,
  output var  logic       cnt
);
  int bcnt [4];
  initial begin
    tick = 1'b0;
    trig = 1'b1;
    cnt  = 1'b1;
    bcnt = '{0, 0, 0, 0};
  end
  // one count per registered pulse on each baud output
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (baud[i] === 1'b1) begin
        bcnt[i]++;
      end
    end
  end
  // ticks are single-cycle with a gap, never back to back
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask
  task automatic set_trig(input logic v);
    @(posedge clk);
    trig <= v;
  endtask
  // low for two cycles so the detector sees it, then idle high
  task automatic fall(input bit on_cnt);
    @(posedge clk);
    if (on_cnt) begin
      cnt <= 1'b0;
    end else begin
      trig <= 1'b0;
    end
    repeat (2) @(posedge clk);
    cnt  <= 1'b1;
    trig <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the second timer over apb
// assumes zero-wait apb slave and synchronous pins
`include "t2rc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tick;
  logic        trig;
  logic        cnt;
  logic [3:0]  baud;
  logic        irq;
  logic [31:0] rdat;
  logic        rerr;
  logic [15:0] v16;
  logic [15:0] rl;
  logic [15:0] cv;
  int          b0 [4];
  int          errors;
  int          tests_run;
  int          cyc;
  int          nt;

  t2rc_timer i_dut (
    .clk                   (clk),
    .reset                 (reset),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .prescaled_timer_clock (tick),
    .ext_trigger_pin       (trig),
    .count_pin             (cnt),
    .uart_a_tx_baud        (baud[0]),
    .uart_a_rx_baud        (baud[1]),
    .uart_b_tx_baud        (baud[2]),
    .uart_b_rx_baud        (baud[3]),
    .irq                   (irq)
  );
  t2rc_pins i_pins (
    .clk  (clk),
    .baud (baud),
    .tick (tick),
    .trig (trig),
    .cnt  (cnt)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // up-count model: wrap past ffff loads the reload value
  function automatic logic [15:0] up(input logic [15:0] c, input logic [15:0] r, input int n);
    for (int i = 0; i < n; i++) begin
      c = (c == 16'hffff) ? r : c + 16'h1;
    end
    return c;
  endfunction
  // waits as long as the slave needs; only the cycle ceiling ends a hang
  task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rd(input logic [13:0] i);
    apb(1'b0, i, 32'h0);
  endtask
  // pair halves are separate byte registers, lo first
  task automatic w16(input logic [13:0] i, input logic [15:0] v);
    wr(i, {24'h0, v[7:0]});
    wr(i + 14'h1, {24'h0, v[15:8]});
  endtask
  task automatic r16(input logic [13:0] i);
    rd(i);
    v16[7:0] = rdat[7:0];
    rd(i + 14'h1);
    v16[15:8] = rdat[7:0];
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0;
    reset   = 1'b1;
    rl = 16'($urandom(88467));
    rl = 16'($urandom) & 16'h7fff;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(14'h0418 + 14'(i));
      chk("reset value", 32'h0, rdat);
    end
    wr(14'h0422, 32'hff);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    rd(14'h0422);
    chk("unmapped data", 32'h0, rdat);
    wr(`T2RC_IDX_MODE, 32'hff);
    rd(`T2RC_IDX_MODE);
    chk("mode mask", 32'h31, rdat);
    wr(`T2RC_IDX_MODE, 32'h0);
    w16(`T2RC_IDX_RLD_LO, rl);
    w16(`T2RC_IDX_CNT_LO, 16'hfffe);
    wr(`T2RC_IDX_IMASK, 32'h3);
    i_pins.ticks(2);
    r16(`T2RC_IDX_CNT_LO);
    chk("stopped count", 32'hfffe, {16'h0, v16});
    wr(`T2RC_IDX_CTRL, 32'h04);
    i_pins.ticks(2);
    r16(`T2RC_IDX_CNT_LO);
    chk("reload count", {16'h0, up(16'hfffe, rl, 2)}, {16'h0, v16});
    rd(`T2RC_IDX_CTRL);
    chk("wrap flag", 32'h84, rdat);
    chk_irq(1'b1);
    wr(`T2RC_IDX_IST, 32'h1);
    chk_irq(1'b0);
    cv = 16'hfffc | 16'($urandom % 4);
    nt = int'($urandom % 8) + 1;
    w16(`T2RC_IDX_CNT_LO, cv);
    i_pins.ticks(nt);
    r16(`T2RC_IDX_CNT_LO);
    chk("random reload count", {16'h0, up(cv, rl, nt)}, {16'h0, v16});
    w16(`T2RC_IDX_CNT_LO, ~rl);
    wr(`T2RC_IDX_CTRL, 32'h0c);
    i_pins.fall(1'b0);
    r16(`T2RC_IDX_CNT_LO);
    chk("trigger reload", {16'h0, rl}, {16'h0, v16});
    rd(`T2RC_IDX_CTRL);
    chk("reload event flag", 32'h4c, rdat);
    chk_irq(1'b1);
    wr(`T2RC_IDX_IST, 32'h3);
    cv = 16'($urandom);
    w16(`T2RC_IDX_CNT_LO, cv);
    wr(`T2RC_IDX_CTRL, 32'h0d);
    i_pins.fall(1'b0);
    r16(`T2RC_IDX_CAP_LO);
    chk("capture", {16'h0, cv}, {16'h0, v16});
    rd(`T2RC_IDX_CTRL);
    chk("capture event flag", 32'h4d, rdat);
    w16(`T2RC_IDX_CNT_LO, 16'hffff);
    wr(`T2RC_IDX_CTRL, 32'h05);
    i_pins.ticks(1);
    r16(`T2RC_IDX_CNT_LO);
    chk("capture wrap", 32'h0, {16'h0, v16});
    rd(`T2RC_IDX_CTRL);
    chk("capture wrap flag", 32'h85, rdat);
    wr(`T2RC_IDX_IST, 32'h3);
    wr(`T2RC_IDX_MODE, 32'h1);
    i_pins.set_trig(1'b0);
    w16(`T2RC_IDX_CNT_LO, rl + 16'h1);
    wr(`T2RC_IDX_CTRL, 32'h04);
    i_pins.ticks(2);
    r16(`T2RC_IDX_CNT_LO);
    chk("down underflow", 32'hffff, {16'h0, v16});
    rd(`T2RC_IDX_CTRL);
    chk("down flags", 32'hc4, rdat);
    i_pins.set_trig(1'b1);
    i_pins.ticks(1);
    r16(`T2RC_IDX_CNT_LO);
    chk("up overflow", {16'h0, rl}, {16'h0, v16});
    rd(`T2RC_IDX_CTRL);
    chk("toggle back", 32'h84, rdat);
    rd(`T2RC_IDX_IST);
    chk("no event status", 32'h1, rdat);
    for (int k = 0; k < 4; k++) begin
      wr(`T2RC_IDX_IST, 32'h3);
      wr(`T2RC_IDX_MODE, k > 1 ? 32'h10 << (k - 2) : 32'h0);
      w16(`T2RC_IDX_CNT_LO, 16'hffff);
      wr(`T2RC_IDX_CTRL, k < 2 ? (32'h10 << k) | 32'h4 : 32'h4);
      b0 = i_pins.bcnt;
      i_pins.ticks(1);
      repeat (3) @(posedge clk);
      for (int j = 0; j < 4; j++) begin
        chk("baud pulse", 32'(j == k), 32'(i_pins.bcnt[j] - b0[j]));
      end
      r16(`T2RC_IDX_CNT_LO);
      chk("baud reload", {16'h0, rl}, {16'h0, v16});
      rd(`T2RC_IDX_IST);
      chk("baud no status", 32'h0, rdat);
    end
    wr(`T2RC_IDX_MODE, 32'h0);
    w16(`T2RC_IDX_CNT_LO, rl);
    wr(`T2RC_IDX_CTRL, 32'h06);
    i_pins.fall(1'b1);
    i_pins.fall(1'b1);
    i_pins.ticks(2);
    r16(`T2RC_IDX_CNT_LO);
    chk("event count", {16'h0, up(rl, rl, 2)}, {16'h0, v16});
    give_verdict();
  end
endmodule
`default_nettype wire
